// ### core/iols_ms_timer.sv
// millisecond interval timer with a one-cycle pulse at each interval end
`default_nettype none

module iols_ms_timer #(
  parameter int CYC_PER_MS = 250000,
  parameter int MS_W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // control
  input wire logic run,
  input wire logic [MS_W-1:0] limit_ms,
  // event
  output logic expired
);

  localparam int CW = $clog2(CYC_PER_MS + 1);
  localparam logic [CW-1:0] CYC_END = CW'(CYC_PER_MS - 1);
  localparam logic [CW-1:0] CYC_ONE = CW'(1);
  localparam logic [MS_W-1:0] MS_ONE = MS_W'(1);

  logic [CW-1:0] cyc_ff;
  logic [MS_W-1:0] ms_ff;
  logic tick_ff;

  wire cyc_end_w = (cyc_ff == CYC_END);
  wire ms_end_w = (ms_ff == limit_ms - MS_ONE);

  // a stopped timer restarts from zero so the first interval is whole
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cyc_ff <= '0;
      ms_ff <= '0;
      tick_ff <= 1'b0;
    end else if (!run) begin
      cyc_ff <= '0;
      ms_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cyc_ff <= cyc_end_w ? '0 : cyc_ff + CYC_ONE;
      ms_ff <= !cyc_end_w ? ms_ff : (ms_end_w ? '0 : ms_ff + MS_ONE);
      tick_ff <= cyc_end_w && ms_end_w;
    end
  end

  assign expired = tick_ff;

endmodule : iols_ms_timer

`default_nettype wire

// ### core/iols_rec_mem.sv
// record byte buffer, one write port and one registered read port
`default_nettype none

module iols_rec_mem #(
  parameter int DW = 8,
  parameter int DEPTH = 32,
  parameter int AW = $clog2(DEPTH)
) (
  // clock
  input wire logic clk_sys,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // read port
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem_ff [DEPTH];
  logic [DW-1:0] rdata_ff;

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem_ff[waddr] <= wdata;
    end
    rdata_ff <= mem_ff[raddr];
  end

  assign rdata = rdata_ff;

endmodule : iols_rec_mem

`default_nettype wire

// ### core/iols_sampler.sv
// i/o line sampler: pin modes, sample records, periodic sampling, forwarding
`default_nettype none

module iols_sampler
  import iols_pkg::*;
#(
  parameter int CYC_PER_MS = MS_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // pin mode settings
  input wire logic [MODE_W-1:0] line0_mode_setting,
  input wire logic [MODE_W-1:0] line1_mode_setting,
  input wire logic [MODE_W-1:0] line2_mode_setting,
  input wire logic [MODE_W-1:0] line3_mode_setting,
  input wire logic [MODE_W-1:0] line4_mode_setting,
  input wire logic [MODE_W-1:0] line5_mode_setting,
  input wire logic [MODE_W-1:0] line6_mode_setting,
  input wire logic [MODE_W-1:0] line7_mode_setting,
  input wire logic [MODE_W-1:0] line8_mode_setting,
  input wire logic [MODE_W-1:0] line9_mode_setting,
  input wire logic [MODE_W-1:0] line10_mode_setting,
  input wire logic [MODE_W-1:0] line11_mode_setting,
  input wire logic [MODE_W-1:0] line12_mode_setting,
  input wire logic [NUM_LINES-1:0] pull_enable_mask,
  input wire logic [NUM_LINES-1:0] pull_direction_mask,
  // pins
  input wire logic [NUM_LINES-1:0] gpio_in,
  output logic [NUM_LINES-1:0] gpio_out,
  output logic [NUM_LINES-1:0] gpio_oe_n,
  output logic [NUM_LINES-1:0] pull_up_en,
  output logic [NUM_LINES-1:0] pull_down_en,
  output logic [NUM_LINES-1:0] alt_fn_en,
  output logic [1:0] pwm_en,
  // analog converter results
  input wire logic [ADC_W-1:0] analog_input_0,
  input wire logic [ADC_W-1:0] analog_input_1,
  input wire logic [ADC_W-1:0] analog_input_2,
  input wire logic [ADC_W-1:0] analog_input_3,
  input wire logic [ADC_W-1:0] analog_input_4,
  input wire logic [ADC_W-1:0] analog_input_5,
  // sampling control
  input wire logic sample_query_command,
  input wire iols_src_t sample_query_src,
  input wire logic [PERIOD_W-1:0] sample_period_ms,
  input wire logic [ADDR_W-1:0] dest_addr_high,
  input wire logic [ADDR_W-1:0] dest_addr_low,
  output logic query_error,
  // sleep
  input wire logic sleep_enabled,
  input wire logic awake,
  input wire logic [PERIOD_W-1:0] wake_hold_time,
  output logic sleep_ready,
  // outgoing record stream
  output logic rec_valid,
  output logic [7:0] rec_byte,
  output logic rec_last,
  input wire logic rec_ready,
  output iols_src_t rec_src,
  output logic [7:0] rec_frame_type,
  output logic [2*ADDR_W-1:0] rec_dest_addr,
  // received samples from the radio
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_last,
  input wire logic [1:0] framed_api_select,
  output logic fwd_valid,
  output logic [7:0] fwd_byte,
  output logic fwd_last
);

  // ---- pin mode decode
  logic [MODE_W-1:0] mode_w [NUM_LINES];
  logic [ADC_W-1:0] an_in_w [NUM_ANALOG];
  logic [NUM_LINES-1:0] din_w, dout_w, dhigh_w, an_w, alt_w;

  assign mode_w[0] = line0_mode_setting;
  assign mode_w[1] = line1_mode_setting;
  assign mode_w[2] = line2_mode_setting;
  assign mode_w[3] = line3_mode_setting;
  assign mode_w[4] = line4_mode_setting;
  assign mode_w[5] = line5_mode_setting;
  assign mode_w[6] = line6_mode_setting;
  assign mode_w[7] = line7_mode_setting;
  assign mode_w[8] = line8_mode_setting;
  assign mode_w[9] = line9_mode_setting;
  assign mode_w[10] = line10_mode_setting;
  assign mode_w[11] = line11_mode_setting;
  assign mode_w[12] = line12_mode_setting;
  assign an_in_w[0] = analog_input_0;
  assign an_in_w[1] = analog_input_1;
  assign an_in_w[2] = analog_input_2;
  assign an_in_w[3] = analog_input_3;
  assign an_in_w[4] = analog_input_4;
  assign an_in_w[5] = analog_input_5;

  for (genvar i = 0; i < NUM_LINES; i++) begin : g_mode
    assign din_w[i] = (mode_w[i] == MODE_DIN);
    assign dout_w[i] = (mode_w[i] == MODE_DOUT_LOW) || (mode_w[i] == MODE_DOUT_HIGH);
    assign dhigh_w[i] = (mode_w[i] == MODE_DOUT_HIGH);
    assign an_w[i] = (mode_w[i] == MODE_ANALOG);
    assign alt_w[i] = (mode_w[i] == MODE_RESERVED) ||
                      ((mode_w[i] >= MODE_ALT_LO) && (mode_w[i] <= MODE_ALT_HI));
  end

  // only the analog-capable lines contribute to the analog mask
  wire [NUM_ANALOG-1:0] amask_w = an_w[NUM_ANALOG-1:0];
  wire inputs_defined_w = (|din_w) || (|amask_w);

  // ---- pins
  logic [NUM_LINES-1:0] gpio_meta_ff, gpio_sync_ff;
  logic [NUM_LINES-1:0] gpio_out_ff, gpio_oe_n_ff, pull_up_ff, pull_dn_ff, alt_ff;
  logic [1:0] pwm_ff;
  wire [NUM_LINES-1:0] pull_up_req_w = pull_enable_mask & pull_direction_mask;
  wire [NUM_LINES-1:0] pull_dn_req_w = pull_enable_mask & ~pull_direction_mask;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      gpio_meta_ff <= '0;
      gpio_sync_ff <= '0;
      gpio_out_ff <= '0;
      gpio_oe_n_ff <= '1;
      pull_up_ff <= '0;
      pull_dn_ff <= '0;
      alt_ff <= '0;
      pwm_ff <= '0;
    end else begin
      gpio_meta_ff <= gpio_in;
      gpio_sync_ff <= gpio_meta_ff;
      gpio_out_ff <= dhigh_w;
      gpio_oe_n_ff <= ~dout_w;
      pull_up_ff <= pull_up_req_w;
      pull_dn_ff <= pull_dn_req_w;
      alt_ff <= alt_w;
      pwm_ff <= {an_w[PWM1_LINE], an_w[PWM0_LINE]};
    end
  end

  // ---- timers
  logic wake_done_ff, period_tick_w, wake_tick_w;
  wire sleep_gate_w = sleep_enabled && (!awake || wake_done_ff);
  wire period_run_w = (sample_period_ms != '0) && !sleep_gate_w;
  wire wake_run_w = sleep_enabled && awake && !wake_done_ff && (wake_hold_time != '0);

  iols_ms_timer #(.CYC_PER_MS(CYC_PER_MS), .MS_W(PERIOD_W)) u_period_tmr (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(period_run_w),
    .limit_ms(sample_period_ms),
    .expired(period_tick_w)
  );

  iols_ms_timer #(.CYC_PER_MS(CYC_PER_MS), .MS_W(PERIOD_W)) u_wake_tmr (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(wake_run_w),
    .limit_ms(wake_hold_time),
    .expired(wake_tick_w)
  );

  // ---- request arbitration; a query is served ahead of a periodic sample
  iols_state_t state_ff, nxt_state;
  logic query_pend_ff, period_pend_ff, err_ff, text_ff;
  iols_src_t query_src_ff, src_ff;
  wire is_idle_w = (state_ff == ST_IDLE);
  wire serve_query_w = is_idle_w && query_pend_ff;
  wire serve_period_w = is_idle_w && !query_pend_ff && period_pend_ff;
  wire start_w = (serve_query_w || serve_period_w) && inputs_defined_w;
  wire nxt_query_pend = sample_query_command || (query_pend_ff && !serve_query_w);
  wire nxt_period_pend = period_tick_w || (period_pend_ff && !serve_period_w);
  wire nxt_err = serve_query_w && !inputs_defined_w;
  wire nxt_wake_done = awake && (wake_done_ff || wake_tick_w);

  // ---- record snapshot and byte selection
  logic [NUM_LINES-1:0] snap_dmask_ff, snap_dstate_ff;
  logic [NUM_ANALOG-1:0] snap_amask_ff;
  logic [ADC_W-1:0] snap_an_ff [NUM_ANALOG];
  logic [4:0] k_ff;
  logic cr_pend_ff;
  logic [REC_AW-1:0] wptr_ff, rd_ptr_ff;
  logic [7:0] item_byte_w;
  logic item_valid_w, item_end_w;
  logic [15:0] dmask16_w, dstate16_w, an16_w;
  logic [4:0] an_off_w;

  assign dmask16_w = 16'(snap_dmask_ff);
  assign dstate16_w = 16'(snap_dstate_ff);
  assign an_off_w = k_ff - K_ANALOG0;
  assign an16_w = 16'(snap_an_ff[an_off_w[3:1]]);

  always_comb begin
    item_byte_w = an_off_w[0] ? an16_w[7:0] : an16_w[15:8];
    item_valid_w = snap_amask_ff[an_off_w[3:1]];
    item_end_w = an_off_w[0];
    case (k_ff)
      K_COUNT: begin
        item_byte_w = SAMPLE_SETS;
        item_valid_w = 1'b1;
        item_end_w = 1'b1;
      end
      K_DMASK_HI: begin
        item_byte_w = dmask16_w[15:8];
        item_valid_w = 1'b1;
        item_end_w = 1'b0;
      end
      K_DMASK_LO: begin
        item_byte_w = dmask16_w[7:0];
        item_valid_w = 1'b1;
        item_end_w = 1'b1;
      end
      K_AMASK: begin
        item_byte_w = 8'(snap_amask_ff);
        item_valid_w = 1'b1;
        item_end_w = 1'b1;
      end
      K_DSTATE_HI: begin
        item_byte_w = dstate16_w[15:8];
        item_valid_w = (snap_dmask_ff != '0);
        item_end_w = 1'b0;
      end
      K_DSTATE_LO: begin
        item_byte_w = dstate16_w[7:0];
        item_valid_w = (snap_dmask_ff != '0);
        item_end_w = 1'b1;
      end
      default: begin
      end
    endcase
  end

  // ---- building: each kept byte goes to the buffer, a delimiter after each field in text mode
  wire building_w = (state_ff == ST_BUILD);
  wire hold_k_w = !cr_pend_ff && item_valid_w && item_end_w && text_ff;
  wire mem_we_w = building_w && (cr_pend_ff || item_valid_w);
  wire [7:0] mem_wdata_w = cr_pend_ff ? FIELD_DELIM : item_byte_w;
  wire build_done_w = building_w && !hold_k_w && (k_ff == K_LAST);

  // ---- sending: one read, one load, one handshake per byte
  logic rec_valid_ff, rec_last_ff, fetch_ff, fwd_valid_ff, fwd_last_ff;
  logic [7:0] rec_byte_ff, rec_frame_ff, fwd_byte_ff, mem_rdata_w;
  logic [2*ADDR_W-1:0] rec_dest_ff;
  wire sending_w = (state_ff == ST_SEND);
  wire issue_w = sending_w && !rec_valid_ff && !fetch_ff && (rd_ptr_ff != wptr_ff);
  wire [REC_AW-1:0] rd_next_w = rd_ptr_ff + REC_AW'(K_ONE);
  wire handshake_w = rec_valid_ff && rec_ready;
  wire [7:0] start_frame_w = (query_src_ff == SRC_TEXT) ? NO_FRAME_TYPE : RESP_FRAME_TYPE;

  iols_rec_mem #(.DW(8), .DEPTH(REC_DEPTH)) u_rec_mem (
    .clk_sys(clk_sys),
    .we(mem_we_w),
    .waddr(wptr_ff),
    .wdata(mem_wdata_w),
    .raddr(rd_ptr_ff),
    .rdata(mem_rdata_w)
  );

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: nxt_state = start_w ? ST_BUILD : ST_IDLE;
      ST_BUILD: nxt_state = build_done_w ? ST_SEND : ST_BUILD;
      ST_SEND: nxt_state = (handshake_w && rec_last_ff) ? ST_IDLE : ST_SEND;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      query_pend_ff <= 1'b0;
      period_pend_ff <= 1'b0;
      err_ff <= 1'b0;
      wake_done_ff <= 1'b0;
      query_src_ff <= SRC_TEXT;
    end else begin
      state_ff <= nxt_state;
      query_pend_ff <= nxt_query_pend;
      period_pend_ff <= nxt_period_pend;
      err_ff <= nxt_err;
      wake_done_ff <= nxt_wake_done;
      if (sample_query_command) begin
        query_src_ff <= sample_query_src;
      end
    end
  end

  // snapshot is taken once so the record is consistent even if pins move while it is sent
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      snap_dmask_ff <= '0;
      snap_dstate_ff <= '0;
      snap_amask_ff <= '0;
      snap_an_ff <= '{default: '0};
      src_ff <= SRC_TEXT;
      text_ff <= 1'b0;
      rec_frame_ff <= NO_FRAME_TYPE;
      rec_dest_ff <= '0;
    end else if (start_w) begin
      snap_dmask_ff <= din_w;
      snap_dstate_ff <= gpio_sync_ff & din_w;
      snap_amask_ff <= amask_w;
      snap_an_ff <= an_in_w;
      src_ff <= serve_query_w ? query_src_ff : SRC_PERIODIC;
      text_ff <= serve_query_w && (query_src_ff == SRC_TEXT);
      rec_frame_ff <= serve_query_w ? start_frame_w : NO_FRAME_TYPE;
      rec_dest_ff <= {dest_addr_high, dest_addr_low};
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      k_ff <= K_COUNT;
      cr_pend_ff <= 1'b0;
      wptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else if (start_w) begin
      k_ff <= K_COUNT;
      cr_pend_ff <= 1'b0;
      wptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (building_w) begin
        cr_pend_ff <= hold_k_w;
        k_ff <= hold_k_w ? k_ff : k_ff + K_ONE;
      end
      if (mem_we_w) begin
        wptr_ff <= wptr_ff + REC_AW'(K_ONE);
      end
      if (fetch_ff) begin
        rd_ptr_ff <= rd_next_w;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fetch_ff <= 1'b0;
      rec_valid_ff <= 1'b0;
      rec_byte_ff <= '0;
      rec_last_ff <= 1'b0;
    end else begin
      fetch_ff <= issue_w;
      if (fetch_ff) begin
        rec_valid_ff <= 1'b1;
        rec_byte_ff <= mem_rdata_w;
        rec_last_ff <= (rd_next_w == wptr_ff);
      end else if (handshake_w) begin
        rec_valid_ff <= 1'b0;
      end
    end
  end

  // samples from the radio pass through only in framed mode
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fwd_valid_ff <= 1'b0;
      fwd_byte_ff <= '0;
      fwd_last_ff <= 1'b0;
    end else begin
      fwd_valid_ff <= rx_valid && (framed_api_select != API_TRANSPARENT);
      fwd_byte_ff <= rx_byte;
      fwd_last_ff <= rx_last;
    end
  end

  assign gpio_out = gpio_out_ff;
  assign gpio_oe_n = gpio_oe_n_ff;
  assign pull_up_en = pull_up_ff;
  assign pull_down_en = pull_dn_ff;
  assign alt_fn_en = alt_ff;
  assign pwm_en = pwm_ff;
  assign query_error = err_ff;
  assign sleep_ready = wake_done_ff;
  assign rec_valid = rec_valid_ff;
  assign rec_byte = rec_byte_ff;
  assign rec_last = rec_last_ff;
  assign rec_src = src_ff;
  assign rec_frame_type = rec_frame_ff;
  assign rec_dest_addr = rec_dest_ff;
  assign fwd_valid = fwd_valid_ff;
  assign fwd_byte = fwd_byte_ff;
  assign fwd_last = fwd_last_ff;

  // ---- checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  AST_MODE_DRIVE: assert property (
    (line0_mode_setting == MODE_DOUT_HIGH) |=> (!gpio_oe_n[0] && gpio_out[0]))
    else $error("line 0 not driven high in output-high mode");
  AST_PULL: assert property (
    pull_up_req_w[0] |=> (pull_up_en[0] && !pull_down_en[0]))
    else $error("pull-up not applied on line 0");
  AST_ERR_EMPTY: assert property (
    query_error |-> ($past(is_idle_w) && !$past(inputs_defined_w)))
    else $error("error answer while inputs are defined");
  AST_FIRST_BYTE: assert property (
    (rec_valid && (rd_ptr_ff == REC_AW'(K_ONE))) |-> (rec_byte == SAMPLE_SETS))
    else $error("first record byte is not the sample count");
  AST_NO_DSTATE: assert property (
    (building_w && (k_ff == K_DSTATE_HI) && (snap_dmask_ff == '0)) |-> !mem_we_w)
    else $error("digital state written with no digital line enabled");
  AST_TEXT_DELIM: assert property (
    (building_w && hold_k_w) |=> (mem_we_w && (mem_wdata_w == FIELD_DELIM)))
    else $error("text field not followed by a carriage return");
  AST_RESP_TYPE: assert property (
    (rec_valid && ((rec_src == SRC_LOCAL) || (rec_src == SRC_REMOTE)))
      |-> (rec_frame_type == RESP_FRAME_TYPE))
    else $error("framed answer without response frame type");
  AST_PERIOD_OFF: assert property (
    (sample_period_ms == '0)[*2] |-> !period_tick_w)
    else $error("periodic sample with period zero");
  AST_FWD_DROP: assert property (
    (framed_api_select == API_TRANSPARENT) |=> !fwd_valid)
    else $error("sample forwarded in transparent mode");
  AST_NEED_INPUT: assert property (
    $rose(building_w) |-> ((snap_dmask_ff != '0) || (snap_amask_ff != '0)))
    else $error("record built with no input enabled");
  AST_SLEEP_STOP: assert property (
    (sleep_enabled && sleep_ready) |=> !period_tick_w)
    else $error("periodic sample after wake hold expired");

endmodule : iols_sampler

`default_nettype wire

// ### dv/io_line_sampler_bench.sv
// self-checking bench of the i/o line sampler
`default_nettype none
module io_line_sampler_bench import iols_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, reset, q, slp, awk, rxv, rxl, stall, qerr, slr, rv, rl, rr, fv, fl;
  logic [3:0] md[13];
  logic [12:0] pen, pdir, gin, gout, goe, pu, pdn, alt;
  logic [9:0] an[6];
  logic [15:0] per, hold;
  logic [31:0] dh, dl;
  logic [7:0] rxb, rb, rft, fb;
  logic [1:0] api, pwm;
  logic [63:0] rda;
  iols_src_t qs, rs;
  int fail_count, checks_done;
  int lasts;
  logic [7:0] exp[$], r[$];
  iols_sampler #(.CYC_PER_MS(4)) i_dut (.clk_sys(clk_sys), .reset(reset),
    .line0_mode_setting(md[0]), .line1_mode_setting(md[1]), .line2_mode_setting(md[2]),
    .line3_mode_setting(md[3]), .line4_mode_setting(md[4]), .line5_mode_setting(md[5]),
    .line6_mode_setting(md[6]), .line7_mode_setting(md[7]), .line8_mode_setting(md[8]),
    .line9_mode_setting(md[9]), .line10_mode_setting(md[10]),
    .line11_mode_setting(md[11]), .line12_mode_setting(md[12]),
    .pull_enable_mask(pen), .pull_direction_mask(pdir), .gpio_in(gin), .gpio_out(gout),
    .gpio_oe_n(goe), .pull_up_en(pu), .pull_down_en(pdn), .alt_fn_en(alt), .pwm_en(pwm),
    .analog_input_0(an[0]), .analog_input_1(an[1]), .analog_input_2(an[2]),
    .analog_input_3(an[3]), .analog_input_4(an[4]), .analog_input_5(an[5]),
    .sample_query_command(q), .sample_query_src(qs), .sample_period_ms(per),
    .dest_addr_high(dh), .dest_addr_low(dl), .query_error(qerr), .sleep_enabled(slp),
    .awake(awk), .wake_hold_time(hold), .sleep_ready(slr), .rec_valid(rv), .rec_byte(rb),
    .rec_last(rl), .rec_ready(rr), .rec_src(rs), .rec_frame_type(rft),
    .rec_dest_addr(rda), .rx_valid(rxv), .rx_byte(rxb), .rx_last(rxl),
    .framed_api_select(api), .fwd_valid(fv), .fwd_byte(fb), .fwd_last(fl));
  iols_sink i_sink (.clk_sys(clk_sys), .reset(reset), .stall(stall), .rec_valid(rv),
    .rec_byte(rb), .rec_ready(rr));
  always #2 clk_sys = ~clk_sys;
  // counts accepted bytes that carry the end-of-record mark
  always @(posedge clk_sys) begin
    if (rv && rr && rl) lasts++;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] want);
    checks_done++;
    if (got !== want) begin
      fail_count++;
      $display("Error at %0t: got %0h want %0h", $time, got, want);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wt
  task automatic setm(input logic [51:0] v);
    @(posedge clk_sys);
    for (int i = 0; i < 13; i++) md[i] <= v[4*i+:4];
  endtask : setm
  task automatic query(input iols_src_t s);
    @(posedge clk_sys);
    q <= 1'b1;
    qs <= s;
    @(posedge clk_sys);
    q <= 1'b0;
  endtask : query
  // waits under a bound for n bytes, then compares them with exp and counts record ends
  task automatic take(input int n, input int recs);
    int i;
    for (i = 0; i < 600 && i_sink.got.size() < n; i++) @(posedge clk_sys);
    // one more edge so both counters have seen the final handshake
    @(posedge clk_sys);
    chk(i_sink.got.size() >= n, 1);
    foreach (exp[k]) chk(i_sink.got[k], exp[k]);
    chk(lasts, recs);
    lasts = 0;
    i_sink.got.delete();
  endtask : take
  task automatic t_pins;
    setm(52'h0_0200_0003_7145);
    pen <= 13'h000F;
    pdir <= 13'h0005;
    wt(3);
    chk(goe, 13'h1FFC);
    chk(gout, 13'h0001);
    chk(alt, 13'h000C);
    chk(pwm, 2'h1);
    chk(pu, 13'h0005);
    chk(pdn, 13'h000A);
  endtask : t_pins
  task automatic t_err;
    int i;
    int seen;
    seen = 0;
    setm(52'h0_0000_0000_0054);
    wt(4);
    query(SRC_LOCAL);
    for (i = 0; i < 10; i++) begin
      @(posedge clk_sys);
      if (qerr === 1'b1) seen++;
    end
    chk(seen, 1);
    chk(i_sink.got.size(), 0);
  endtask : t_err
  task automatic t_query;
    setm(52'h0_3300_0000_3322);
    gin <= 13'h0428;
    an[0] <= 10'h3D0;
    an[1] <= 10'h120;
    wt(4);
    // unmasked line 5 is high but must not show in the state word
    r = '{8'h01, 8'h0C, 8'h0C, 8'h03, 8'h04, 8'h08, 8'h03, 8'hD0, 8'h01, 8'h20};
    exp = {r, r};
    query(SRC_LOCAL);
    query(SRC_REMOTE);
    take(20, 2);
    chk(rft, 8'h88);
    chk(rs, SRC_REMOTE);
  endtask : t_query
  task automatic t_text;
    setm(52'h0_0000_0020_0000);
    an[5] <= 10'h2AB;
    stall <= 1'b1;
    wt(4);
    exp = '{8'h01, 8'h0D, 8'h00, 8'h00, 8'h0D, 8'h20, 8'h0D, 8'h02, 8'hAB, 8'h0D};
    query(SRC_TEXT);
    take(10, 1);
    chk(rft, 8'h00);
    stall <= 1'b0;
  endtask : t_text
  task automatic t_fwd;
    int seen;
    seen = 0;
    @(posedge clk_sys);
    rxv <= 1'b1;
    rxb <= 8'h5A;
    rxl <= 1'b1;
    @(posedge clk_sys);
    rxv <= 1'b0;
    repeat (3) begin
      @(posedge clk_sys);
      if (fv === 1'b1) seen++;
    end
    chk(seen, 0);
    api <= 2'h1;
    rxv <= 1'b1;
    @(posedge clk_sys);
    rxv <= 1'b0;
    @(posedge clk_sys);
    chk({fv, fl, fb}, 10'h35A);
  endtask : t_fwd
  task automatic t_period;
    setm(52'h0_0000_0000_0300);
    gin <= 13'h0004;
    wt(4);
    per <= 16'h0001;
    r = '{8'h01, 8'h00, 8'h04, 8'h00, 8'h00, 8'h04};
    exp = {r, r};
    take(12, 2);
    chk(rs, SRC_PERIODIC);
    chk(rda, {dh, dl});
    per <= 16'h0000;
    wt(100);
    i_sink.got.delete();
    wt(100);
    chk(i_sink.got.size(), 0);
  endtask : t_period
  task automatic t_sleep;
    slp <= 1'b1;
    awk <= 1'b1;
    per <= 16'h0001;
    wt(100);
    chk(slr, 1'b1);
    i_sink.got.delete();
    wt(100);
    chk(i_sink.got.size(), 0);
    awk <= 1'b0;
    wt(3);
    chk(slr, 1'b0);
  endtask : t_sleep
  initial begin
    {clk_sys, reset, q, slp, awk, rxv, rxl, stall, pen, pdir, gin} = '0;
    {per, rxb, api} = '0;
    qs = SRC_TEXT;
    reset = 1'b1;
    md = '{default: 4'h0};
    an = '{default: 10'h000};
    hold = 16'h0002;
    dh = 32'h1234_5678;
    dl = 32'h9ABC_DEF0;
    wt(20);
    reset <= 1'b0;
    t_pins();
    t_err();
    t_query();
    t_text();
    t_fwd();
    t_period();
    t_sleep();
    print_verdict();
  end
  initial begin
    #80000;
    fail_count++;
    print_verdict();
  end
endmodule : io_line_sampler_bench
`default_nettype wire

// ### dv/iols_sink.sv
// record stream sink that can stall and keeps every accepted byte
`default_nettype none
module iols_sink (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // stream
  input wire logic stall,
  input wire logic rec_valid,
  input wire logic [7:0] rec_byte,
  output logic rec_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  logic [1:0] ph_ff;
  // when stalling, ready only one cycle in four so each byte is held a while
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ph_ff <= 2'h0;
      rec_ready <= 1'b0;
    end else begin
      ph_ff <= ph_ff + 2'h1;
      rec_ready <= !stall || ph_ff == 2'h3;
    end
  end
  always @(posedge clk_sys) begin
    if (rec_valid && rec_ready) begin
      got.push_back(rec_byte);
    end
  end
endmodule : iols_sink
`default_nettype wire

// ### pkg/iols_pkg.sv
// shared constants and types of the i/o line sampler
`default_nettype none

package iols_pkg;

  // line and channel counts, field widths and the pwm line numbers
  localparam int NUM_LINES = 32'h0000_000D;
  localparam int NUM_ANALOG = 32'h0000_0006;
  localparam int ADC_W = 32'h0000_000A;
  localparam int MODE_W = 32'h0000_0004;
  localparam int PERIOD_W = 32'h0000_0010;
  localparam int ADDR_W = 32'h0000_0020;
  localparam int PWM0_LINE = 32'h0000_000A;
  localparam int PWM1_LINE = 32'h0000_000B;

  // pin mode encodings
  localparam logic [3:0] MODE_DISABLED = 4'h0;
  localparam logic [3:0] MODE_RESERVED = 4'h1;
  localparam logic [3:0] MODE_ANALOG = 4'h2;
  localparam logic [3:0] MODE_DIN = 4'h3;
  localparam logic [3:0] MODE_DOUT_LOW = 4'h4;
  localparam logic [3:0] MODE_DOUT_HIGH = 4'h5;
  localparam logic [3:0] MODE_ALT_LO = 4'h6;
  localparam logic [3:0] MODE_ALT_HI = 4'h9;

  // record contents
  localparam logic [7:0] SAMPLE_SETS = 8'h01;
  localparam logic [7:0] RESP_FRAME_TYPE = 8'h88;
  localparam logic [7:0] NO_FRAME_TYPE = 8'h00;
  localparam logic [7:0] FIELD_DELIM = 8'h0D;
  localparam logic [1:0] API_TRANSPARENT = 2'h0;

  // byte slots of a record, in transmit order
  localparam logic [4:0] K_COUNT = 5'h00;
  localparam logic [4:0] K_DMASK_HI = 5'h01;
  localparam logic [4:0] K_DMASK_LO = 5'h02;
  localparam logic [4:0] K_AMASK = 5'h03;
  localparam logic [4:0] K_DSTATE_HI = 5'h04;
  localparam logic [4:0] K_DSTATE_LO = 5'h05;
  localparam logic [4:0] K_ANALOG0 = 5'h06;
  localparam logic [4:0] K_LAST = 5'h11;
  localparam logic [4:0] K_ONE = 5'h01;

  // record buffer
  localparam int REC_DEPTH = 32'h0000_0020;
  localparam int REC_AW = $clog2(REC_DEPTH);

  // millisecond timing at the system clock
  localparam int CLK_PERIOD_NS = 32'h0000_0004;
  localparam int MS_PERIOD_NS = 32'h000F_4240;
  localparam int MS_CYCLES = (MS_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SRC_TEXT = 2'b00,
    SRC_LOCAL = 2'b01,
    SRC_REMOTE = 2'b10,
    SRC_PERIODIC = 2'b11
  } iols_src_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUILD = 2'b01,
    ST_SEND = 2'b11
  } iols_state_t;

endpackage : iols_pkg

`default_nettype wire
